// ==== design/app_pin_port.v ====
// aux pin port: eight pins, 0-2 and 4 mode-dependent, with gpio, irq inputs and alternate
// functions, registers reached over axi4-lite
// assumes frame_sync, bit clock, stop/go and m-bit come from aclk-domain logic
`timescale 1ns/1ps
`include "app_regs.vh"

// Summary of operation
// R1: all pins are inputs after reset
// R2: pins 0-2 become channel select in linecard modes
// R3: direction 1 is input, sampled on readback read
// R4: direction 0 drives drive register bit out
// R5: drive type 0 open drain, 1 push-pull
// R6: readback shows real pin level for outputs too
// R7: pin 5 alternate select gives derived clock
// R8: clock select picks frame sync or bit clock
// R9: pins 6,7 gpio plus irq, masked after reset
// R10: input pins 6,7 set flags, mask suppresses forwarding
// R11: per-pin edge or level trigger selection
// R12: pins 6,7 pull-up off only when push-pull output
// R13: pin 7 alternate select outputs stop/go bit
// R14: pin 4 alternate select carries multiframe bit
// R15: m-bit direction follows operating mode
// R16: strapped pins give channel 0 to 7
// R17: board limits channels by data clock rate
// R18: channel number offsets the highway timeslot
// R19: pin inputs synchronised before any use
module app_pin_port #(
  parameter ADDR_W = 8
) (
  // clock, reset, enable
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              ce,
  // axi4-lite write address and data
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // operating mode from the mode straps
  input  wire [2:0]        op_mode,
  // highway timing and bits, aclk domain
  input  wire              frame_sync,
  input  wire              highway_bit_clock,
  input  wire              stop_go_bit,
  input  wire              multiframe_bit_pin_tx,
  input  wire [4:0]        ts_base,
  output reg               multiframe_bit_pin_rx_ff,
  output reg  [2:0]        chan_sel_ff,
  output reg  [4:0]        ts_sel_ff,
  // aux pins, three signals each
  input  wire [7:0]        pin_in,
  output reg  [7:0]        pin_out_ff,
  output reg  [7:0]        pin_oe_ff,
  output reg  [1:0]        pullup_en_ff,
  // forwarded pin interrupt
  output reg               irq_out_ff
);

  // linecard modes turn pins 0-2 into channel straps
  function is_linecard;
    input [2:0] m;
    begin
      is_linecard = (m == `APP_MODE_LTT) || (m == `APP_MODE_LTS) ||
                    (m == `APP_MODE_NT);
    end
  endfunction

  // m-bit leaves the device only in terminal and trunk modes
  function multiframe_bit_pin_out_mode;
    input [2:0] m;
    begin
      multiframe_bit_pin_out_mode = (m == `APP_MODE_TE) || (m == `APP_MODE_LTT);
    end
  endfunction

  // register file
  reg  [7:0]              pin_direction_reg_ff;
  reg  [7:0]              pin_drive_reg_ff;
  reg  [7:0]              pin_drive_type_reg_ff;
  reg  [`APP_ALT_W-1:0]   pin_altfunc_reg_ff;
  reg  [1:0]              pin_irq_flag_reg_ff;
  reg  [1:0]              pin_irq_mask_reg_ff;

  // write channel holding state
  reg                     aw_have_ff;
  reg  [ADDR_W-1:0]       awaddr_ff;
  reg                     w_have_ff;
  reg  [7:0]              wdata_ff;
  reg                     wstrb0_ff;

  // irq edge history
  reg  [1:0]              irq_prev_ff;

  wire [7:0]              pin_sync;
  wire                    do_wr;
  wire                    wr_ok;
  wire [7:0]              wr_addr;
  wire [7:0]              rd_addr;
  wire                    linecard;
  wire                    multiframe_bit_pin_out;
  wire                    sel_fbs;
  wire                    sel_a4;
  wire                    sel_a5;
  wire                    sel_a7;
  wire [1:0]              trig_level;
  wire [1:0]              irq_in_en;
  wire [1:0]              irq_cur;
  wire [1:0]              irq_set;
  wire [1:0]              irq_clr;
  wire [1:0]              nxt_irq_flag;
  wire [7:0]              nxt_pin_out;
  wire [7:0]              nxt_pin_oe;
  wire [1:0]              nxt_pullup;
  reg  [31:0]             nxt_rdata;
  reg  [1:0]              nxt_rresp;

  // metastable levels never reach readback or irq logic
  app_sync2 #(
    .WIDTH (8)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (pin_in),
    .q       (pin_sync)
  ); // R19

  assign linecard   = is_linecard(op_mode);
  assign multiframe_bit_pin_out   = multiframe_bit_pin_out_mode(op_mode);
  assign sel_fbs    = pin_altfunc_reg_ff[`APP_ALT_FBS];
  assign sel_a4     = pin_altfunc_reg_ff[`APP_ALT_A4];
  assign sel_a5     = pin_altfunc_reg_ff[`APP_ALT_A5];
  assign sel_a7     = pin_altfunc_reg_ff[`APP_ALT_A7];
  assign trig_level = {pin_altfunc_reg_ff[`APP_ALT_EL7],
                       pin_altfunc_reg_ff[`APP_ALT_EL6]};

  // write fires once address and data are both held and no response waits
  assign do_wr   = aw_have_ff & w_have_ff & ~s_axi_bvalid;
  assign wr_addr = awaddr_ff[7:0];
  assign rd_addr = s_axi_araddr[7:0];
  assign wr_ok   = (wr_addr == `APP_ADDR_DIR) || (wr_addr == `APP_ADDR_RDBK) ||
                   (wr_addr == `APP_ADDR_DRV) || (wr_addr == `APP_ADDR_DTYPE) ||
                   (wr_addr == `APP_ADDR_ALT) || (wr_addr == `APP_ADDR_IFLAG) ||
                   (wr_addr == `APP_ADDR_IMASK) || (wr_addr == `APP_ADDR_STAT);

  // axi write address and data channels, taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      awaddr_ff     <= {ADDR_W{1'b0}};
      wdata_ff      <= 8'h00;
      wstrb0_ff     <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff    <= 1'b1;
        awaddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff    <= 1'b1;
        wdata_ff     <= s_axi_wdata[7:0];
        wstrb0_ff    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
      if (do_wr) begin
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `APP_RESP_OKAY;
    end else if (ce) begin
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `APP_RESP_OKAY : `APP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software-written configuration; readback and status ignore writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_direction_reg_ff  <= `APP_RST_DIR;   // R1
      pin_drive_reg_ff      <= `APP_RST_DRV;
      pin_drive_type_reg_ff <= `APP_RST_DTYPE;
      pin_altfunc_reg_ff    <= `APP_RST_ALT;   // R7 R8
      pin_irq_mask_reg_ff   <= `APP_RST_IMASK; // R9
    end else if (ce && do_wr && wstrb0_ff) begin
      case (wr_addr)
        `APP_ADDR_DIR:   pin_direction_reg_ff  <= wdata_ff;
        `APP_ADDR_DRV:   pin_drive_reg_ff      <= wdata_ff; // R4
        `APP_ADDR_DTYPE: pin_drive_type_reg_ff <= wdata_ff;
        `APP_ADDR_ALT:   pin_altfunc_reg_ff    <= wdata_ff[`APP_ALT_W-1:0];
        `APP_ADDR_IMASK: pin_irq_mask_reg_ff   <= wdata_ff[1:0];
        default: begin
        end
      endcase
    end
  end

  // read data mux; readback returns the synced level, two aclk cycles behind the pin
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `APP_RESP_OKAY;
    case (rd_addr)
      `APP_ADDR_DIR:   nxt_rdata[7:0] = pin_direction_reg_ff;
      `APP_ADDR_RDBK:  nxt_rdata[7:0] = pin_sync; // R3 R6
      `APP_ADDR_DRV:   nxt_rdata[7:0] = pin_drive_reg_ff;
      `APP_ADDR_DTYPE: nxt_rdata[7:0] = pin_drive_type_reg_ff;
      `APP_ADDR_ALT:   nxt_rdata[`APP_ALT_W-1:0] = pin_altfunc_reg_ff;
      `APP_ADDR_IFLAG: nxt_rdata[1:0] = pin_irq_flag_reg_ff;
      `APP_ADDR_IMASK: nxt_rdata[1:0] = pin_irq_mask_reg_ff;
      `APP_ADDR_STAT: begin
        nxt_rdata[`APP_STAT_CH_LSB +: 3]   = chan_sel_ff;
        nxt_rdata[`APP_STAT_MODE_LSB +: 3] = op_mode;
      end
      default: nxt_rresp = `APP_RESP_SLVERR;
    endcase
  end

  // read channel; one read in flight, arready drops until rdata is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `APP_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= nxt_rdata;
        s_axi_rresp   <= nxt_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // irq inputs: only while the pin is a plain input
  assign irq_in_en[0] = pin_direction_reg_ff[`APP_PIN_IRQA];
  assign irq_in_en[1] = pin_direction_reg_ff[`APP_PIN_IRQB] & ~sel_a7;
  assign irq_cur      = {pin_sync[`APP_PIN_IRQB], pin_sync[`APP_PIN_IRQA]};

  // level trigger is active low, edge trigger is the falling edge,
  // matching the pulled-up open-collector sources usually hung here
  assign irq_set = irq_in_en & ((trig_level & ~irq_cur) |
                               (~trig_level & irq_prev_ff & ~irq_cur)); // R10 R11

  // write one to clear; a set in the same cycle wins
  assign irq_clr      = (do_wr && wstrb0_ff && wr_addr == `APP_ADDR_IFLAG) ?
                        wdata_ff[1:0] : 2'b00;
  assign nxt_irq_flag = (pin_irq_flag_reg_ff & ~irq_clr) | irq_set;

  // flag storage, edge history and masked forwarding
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_irq_flag_reg_ff <= 2'b00;
      irq_prev_ff         <= 2'b11;
      irq_out_ff          <= 1'b0;
    end else if (ce) begin
      pin_irq_flag_reg_ff <= nxt_irq_flag;                          // R10
      irq_prev_ff         <= irq_cur;
      irq_out_ff          <= |(nxt_irq_flag & ~pin_irq_mask_reg_ff); // R9 R10
    end
  end

  // per-pin drive: gpio first, then mode and alternate overrides
  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1) begin : g_pin
      wire gp_out;
      wire gp_oe;
      wire is_out;
      // open drain only pulls low; push-pull drives both levels
      assign is_out = ~pin_direction_reg_ff[p];                         // R3 R4
      assign gp_out = pin_drive_type_reg_ff[p] ? pin_drive_reg_ff[p] : 1'b0;
      assign gp_oe  = is_out & (pin_drive_type_reg_ff[p] |
                                ~pin_drive_reg_ff[p]);                  // R5
      if (p < 3) begin : g_chan
        assign nxt_pin_out[p] = gp_out;
        assign nxt_pin_oe[p]  = gp_oe & ~linecard;                      // R2
      end else if (p == `APP_PIN_MULTIFRAME_BIT_PIN) begin : g_multiframe_bit_pin
        assign nxt_pin_out[p] = sel_a4 ? multiframe_bit_pin_tx : gp_out;              // R14
        assign nxt_pin_oe[p]  = sel_a4 ? multiframe_bit_pin_out : gp_oe;              // R15
      end else if (p == `APP_PIN_FB) begin : g_fb
        assign nxt_pin_out[p] = ~sel_a5 ? gp_out :
                                sel_fbs ? highway_bit_clock : frame_sync; // R7 R8
        assign nxt_pin_oe[p]  = sel_a5 | gp_oe;                         // R7
      end else if (p == `APP_PIN_IRQB) begin : g_sg
        assign nxt_pin_out[p] = sel_a7 ? stop_go_bit : gp_out;          // R13
        assign nxt_pin_oe[p]  = sel_a7 | gp_oe;                         // R13
      end else begin : g_plain
        assign nxt_pin_out[p] = gp_out;
        assign nxt_pin_oe[p]  = gp_oe;
      end
    end
  endgenerate

  // pull-ups stay on for input and open drain, off for push-pull drive
  assign nxt_pullup[0] = pin_direction_reg_ff[`APP_PIN_IRQA] |
                         ~pin_drive_type_reg_ff[`APP_PIN_IRQA];          // R12
  assign nxt_pullup[1] = ~sel_a7 & (pin_direction_reg_ff[`APP_PIN_IRQB] |
                         ~pin_drive_type_reg_ff[`APP_PIN_IRQB]);         // R12

  // registered pin drive; one cycle after the config registers change
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_ff   <= 8'h00;
      pin_oe_ff    <= 8'h00; // R1
      pullup_en_ff <= 2'b11;
    end else if (ce) begin
      pin_out_ff   <= nxt_pin_out;
      pin_oe_ff    <= nxt_pin_oe;
      pullup_en_ff <= nxt_pullup;
    end
  end

  // channel straps follow the synced pins in linecard modes; the board
  // must keep them inside the range its data clock supports
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan_sel_ff <= 3'h0;
      ts_sel_ff   <= 5'h00;
      multiframe_bit_pin_rx_ff  <= 1'b0;
    end else if (ce) begin
      if (linecard) begin
        chan_sel_ff <= pin_sync[2:0]; // R16 R17
      end else begin
        chan_sel_ff <= 3'h0;
      end
      ts_sel_ff  <= ts_base + {2'b00, chan_sel_ff};                   // R18
      multiframe_bit_pin_rx_ff <= sel_a4 & ~multiframe_bit_pin_out & pin_sync[`APP_PIN_MULTIFRAME_BIT_PIN];     // R15
    end
  end

endmodule // app_pin_port

// ==== design/app_regs.vh ====
// register map, field positions, reset values and mode codes of the aux pin port
// assumes 32-bit axi4-lite data with one aligned word per register
`ifndef APP_REGS_VH
`define APP_REGS_VH

// register byte addresses
`define APP_ADDR_DIR    8'h00
`define APP_ADDR_RDBK   8'h04
`define APP_ADDR_DRV    8'h08
`define APP_ADDR_DTYPE  8'h0c
`define APP_ADDR_ALT    8'h10
`define APP_ADDR_IFLAG  8'h14
`define APP_ADDR_IMASK  8'h18
`define APP_ADDR_STAT   8'h1c

// reset values
`define APP_RST_DIR     8'hff
`define APP_RST_DRV     8'h00
`define APP_RST_DTYPE   8'h00
`define APP_RST_ALT     6'h00
`define APP_RST_IMASK   2'h3

// pin_altfunc_reg fields
`define APP_ALT_FBS     0
`define APP_ALT_A4      1
`define APP_ALT_A5      2
`define APP_ALT_A7      3
`define APP_ALT_EL6     4
`define APP_ALT_EL7     5
`define APP_ALT_W       6

// status register fields
`define APP_STAT_CH_LSB   0
`define APP_STAT_MODE_LSB 4

// operating mode codes on op_mode
`define APP_MODE_TE     3'h0
`define APP_MODE_LTT    3'h1
`define APP_MODE_LTS    3'h2
`define APP_MODE_NT     3'h3
`define APP_MODE_INT    3'h4

// special pin indices
`define APP_PIN_MULTIFRAME_BIT_PIN    4
`define APP_PIN_FB      5
`define APP_PIN_IRQA    6
`define APP_PIN_IRQB    7

// axi responses
`define APP_RESP_OKAY   2'h0
`define APP_RESP_SLVERR 2'h2

`endif

// ==== design/app_sync2.v ====
// two-stage synchroniser for the asynchronous aux pin levels
// assumes the pins are unrelated to aclk; only stage two is read outside
`timescale 1ns/1ps

module app_sync2 #(
  parameter WIDTH = 8
) (
  // clock, reset, enable
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             ce,
  // async levels in, synced levels out
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  genvar i;

  // one flop pair per bit; stage one feeds stage two only
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta_ff <= 1'b1;
          sync_ff <= 1'b1;
        end else if (ce) begin
          meta_ff <= d[i];
          sync_ff <= meta_ff;
        end
      end
      assign q[i] = sync_ff;
    end
  endgenerate

endmodule // app_sync2

// ==== sim/app_pin_monitor.sv ====
// checker for the aux pin port: pin drive, strapped channel, pull-ups, read channel
// assumes it is bound into app_pin_port with ce held high
`timescale 1ns/1ps

module app_pin_monitor (
  // clock and reset
  input wire       aclk,
  input wire       aresetn,
  // mode, straps, timeslot base
  input wire [2:0] op_mode,
  input wire [7:0] pin_in,
  input wire [4:0] ts_base,
  // pin side outputs
  input wire [7:0] pin_oe_ff,
  input wire [7:0] pin_out_ff,
  input wire [1:0] pullup_en_ff,
  input wire [2:0] chan_sel_ff,
  input wire [4:0] ts_sel_ff,
  input wire       multiframe_bit_pin_rx_ff,
  input wire       irq_out_ff,
  // read channel
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // linecard modes hand pins 0 to 2 over to the channel straps
  wire lc_mode = (op_mode == 3'h1) || (op_mode == 3'h2) || (op_mode == 3'h3);

  // reset must be seen even while it is active
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> pin_oe_ff == 8'h00 && !irq_out_ff) else $error("pins driven after reset");
  a_chan_undriven: assert property ($stable(op_mode) && lc_mode
    |-> pin_oe_ff[2:0] == 3'h0) else $error("channel pin driven");
  // five quiet samples cover two sync stages plus the channel register
  a_chan_strap: assert property ((lc_mode && $stable(op_mode) && $stable(pin_in[2:0]))[*5]
    |-> chan_sel_ff == pin_in[2:0]) else $error("strapped channel not taken");
  a_chan_zero: assert property ($stable(op_mode) && !lc_mode
    |-> chan_sel_ff == 3'h0) else $error("channel outside linecard mode");
  a_ts_offset: assert property (1'b1
    |=> ts_sel_ff == $past(ts_base) + $past(chan_sel_ff)) else $error("timeslot not offset");
  a_pullup_input: assert property (!pin_oe_ff[6]
    |-> pullup_en_ff[0]) else $error("pull-up off on released pin");
  a_pullup_pp: assert property (pin_oe_ff[6] && pin_out_ff[6]
    |-> !pullup_en_ff[0]) else $error("pull-up on push-pull pin");
  a_multiframe_bit_pin_output: assert property ($stable(op_mode) && op_mode <= 3'h1
    |-> !multiframe_bit_pin_rx_ff) else $error("m-bit taken in output mode");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid) else $error("read data dropped");
endmodule // app_pin_monitor

bind app_pin_port app_pin_monitor mon_u (
  .aclk, .aresetn, .op_mode, .pin_in, .ts_base, .pin_oe_ff, .pin_out_ff,
  .pullup_en_ff, .chan_sel_ff, .ts_sel_ff, .multiframe_bit_pin_rx_ff, .irq_out_ff,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);

// ==== sim/app_board_model.sv ====
// board model: straps, outside drivers, pull-ups of pins 6 and 7
// assumes the bench sets ext_en and ext_val; a released line holds no value
`timescale 1ns/1ps

module app_board_model (
  // clock
  input wire       aclk,
  // device pin side
  input wire [7:0] pin_out_ff,
  input wire [7:0] pin_oe_ff,
  input wire [1:0] pullup_en_ff,
  // outside drivers and straps
  input wire [7:0] ext_en,
  input wire [7:0] ext_val,
  // resolved levels
  output reg [7:0] pin_lvl
);
  reg     flt_ff = 1'b0;
  integer i;

  // floating lines wander every cycle so a stale level never reads back
  always @(posedge aclk) begin
    flt_ff <= ~flt_ff;
  end
  // outside driver is strongest, then device, then pull-up
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pin_oe_ff[i]) pin_lvl[i] = pin_out_ff[i];
      else if (i >= 6 && pullup_en_ff[i-6]) pin_lvl[i] = 1'b1;
      else pin_lvl[i] = flt_ff ^ i[0];
    end
  end
endmodule // app_board_model

// ==== sim/tb_aux_pin_port.sv ====
// self-checking bench: axi4-lite host, board model, reference values
// assumes the register map header and a 10 MHz aclk
`timescale 1ns/1ps
`include "app_regs.vh"

module tb_aux_pin_port;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg  [2:0]  op_mode = 3'h0;
  reg         frame_sync = 1'b0, highway_bit_clock = 1'b0, stop_go_bit = 1'b0, multiframe_bit_pin_tx = 1'b0;
  reg  [4:0]  ts_base = 5'h00;
  reg  [7:0]  ext_en = 8'h00, ext_val = 8'h00;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp, pullup_en_ff;
  wire [31:0] s_axi_rdata;
  wire [7:0]  pin_in, pin_out_ff, pin_oe_ff;
  wire [2:0]  chan_sel_ff;
  wire [4:0]  ts_sel_ff;
  wire        multiframe_bit_pin_rx_ff, irq_out_ff;
  reg  [31:0] seed = 32'h00002e93, rdv, rd_q;
  reg  [1:0]  rr;
  reg  [7:0]  dir, drv, dtyp, oe_e, rb_e, rb_m;
  integer     num_errors = 0, n_checks = 0, i, k, m;

  app_pin_port dut_u (
    .aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_mode, .frame_sync,
    .highway_bit_clock, .stop_go_bit, .multiframe_bit_pin_tx, .ts_base, .multiframe_bit_pin_rx_ff, .chan_sel_ff,
    .ts_sel_ff, .pin_in, .pin_out_ff, .pin_oe_ff, .pullup_en_ff, .irq_out_ff
  );
  app_board_model brd_u (
    .aclk, .pin_out_ff, .pin_oe_ff, .pullup_en_ff, .ext_en, .ext_val, .pin_lvl(pin_in)
  );

  // 100 ns clock
  always #50 aclk = ~aclk;

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input string n, input [31:0] e, input [31:0] s);
    n_checks = n_checks + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task settle(input integer n);
    repeat (n) @(posedge aclk);
  endtask

  // address and data offered together, each dropped once taken
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask

  task rd(input [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd_q = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  task rc(input [7:0] a, input [31:0] e, input [31:0] msk);
    rd(a);
    chk("rdata", e & msk, rd_q & msk);
  endtask

  // reference pin state for plain gpio use; floating pins are masked out
  task calc;
    for (i = 0; i < 8; i = i + 1) begin
      oe_e[i] = !dir[i] && (dtyp[i] || !drv[i]);
      rb_m[i] = ext_en[i] || oe_e[i] || (i >= 6 && !(!dir[i] && dtyp[i]));
      rb_e[i] = ext_en[i] ? ext_val[i] : (oe_e[i] ? drv[i] : 1'b1);
    end
  endtask

  task test_done;
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors = num_errors + 1;
    test_done;
  end

  initial begin
    settle(4);
    aresetn <= 1'b1;
    // reset values, then an unmapped address
    chk("oe_rst", 8'h00, pin_oe_ff);
    rc(`APP_ADDR_DIR, 32'hff, 32'hffffffff);
    rc(`APP_ADDR_DRV, 32'h00, 32'hffffffff);
    rc(`APP_ADDR_DTYPE, 32'h00, 32'hffffffff);
    rc(`APP_ADDR_ALT, 32'h00, 32'hffffffff);
    rc(`APP_ADDR_IMASK, 32'h03, 32'hffffffff);
    rc(`APP_ADDR_IFLAG, 32'h00, 32'hffffffff);
    wr(8'h20, 32'hff, `APP_RESP_SLVERR);
    rc(8'h20, 32'h0, 32'hffffffff);
    chk("rresp", `APP_RESP_SLVERR, rr);
    // random gpio settings in the two modes that free pins 0 to 2
    for (k = 0; k < 8; k = k + 1) begin
      op_mode <= k[0] ? `APP_MODE_INT : `APP_MODE_TE;
      ext_en <= 8'h00;
      rdv = rnd();
      dir = rdv[7:0];
      drv = rdv[15:8];
      dtyp = rdv[23:16];
      wr(`APP_ADDR_DIR, dir, `APP_RESP_OKAY);
      wr(`APP_ADDR_DRV, drv, `APP_RESP_OKAY);
      wr(`APP_ADDR_DTYPE, dtyp, `APP_RESP_OKAY);
      calc;
      ext_en <= rdv[31:24] & ~oe_e;
      rdv = rnd();
      ext_val <= rdv[7:0];
      settle(4);
      calc;
      chk("pin_oe", oe_e, pin_oe_ff);
      chk("pin_out", drv & oe_e, pin_out_ff & oe_e);
      chk("pullup", {!(!dir[7] && dtyp[7]), !(!dir[6] && dtyp[6])}, pullup_en_ff);
      rc(`APP_ADDR_RDBK, rb_e, rb_m);
    end
    // strapped channel in the linecard modes; fast data clock, all eight allowed
    for (k = 1; k < 4; k = k + 1) begin
      rdv = rnd();
      op_mode <= k[2:0];
      ts_base <= rdv[4:0];
      ext_en <= 8'h07;
      ext_val <= {5'h00, rdv[7:5]};
      wr(`APP_ADDR_DIR, 32'h00, `APP_RESP_OKAY);
      settle(6);
      chk("oe_chan", 8'h00, pin_oe_ff & 8'h07);
      chk("chan_sel", rdv[7:5], chan_sel_ff);
      chk("ts_sel", (rdv[4:0] + rdv[7:5]) & 5'h1f, ts_sel_ff);
      rc(`APP_ADDR_STAT, {k[2:0], 1'b0, rdv[7:5]}, 32'hff);
    end
    // alternate outputs and the m-bit direction in every mode
    wr(`APP_ADDR_DIR, 32'hff, `APP_RESP_OKAY);
    for (k = 0; k < 10; k = k + 1) begin
      m = k >> 1;
      rdv = rnd();
      op_mode <= m[2:0];
      frame_sync <= rdv[0];
      highway_bit_clock <= rdv[1];
      stop_go_bit <= rdv[2];
      multiframe_bit_pin_tx <= rdv[3];
      ext_en <= {3'h0, m >= 2, 4'h0};
      ext_val <= {3'h0, rdv[4], 4'h0};
      wr(`APP_ADDR_ALT, {28'h0, 3'h7, k[0]}, `APP_RESP_OKAY);
      settle(5);
      chk("derived_clock_out", k[0] ? rdv[1] : rdv[0], pin_out_ff[5]);
      chk("sgo", rdv[2], pin_out_ff[7]);
      chk("alt_oe", {1'b1, 1'b0, 1'b1, m < 2}, pin_oe_ff[7:4]);
      chk("multiframe_bit_pin_tx", m < 2 ? rdv[3] : 1'b0, pin_out_ff[4] & pin_oe_ff[4]);
      chk("multiframe_bit_pin_rx", m >= 2 ? rdv[4] : 1'b0, multiframe_bit_pin_rx_ff);
    end
    // pin 6 interrupt: masked, unmasked, edge, level, then as an output
    op_mode <= `APP_MODE_TE;
    ext_en <= 8'h00;
    ext_val <= 8'h00;
    wr(`APP_ADDR_ALT, 32'h00, `APP_RESP_OKAY);
    settle(4);
    wr(`APP_ADDR_IFLAG, 32'h03, `APP_RESP_OKAY);
    ext_en <= 8'h40;
    settle(6);
    rc(`APP_ADDR_IFLAG, 32'h01, 32'h03);
    chk("irq", 1'b0, irq_out_ff);
    wr(`APP_ADDR_IMASK, 32'h02, `APP_RESP_OKAY);
    settle(2);
    chk("irq", 1'b1, irq_out_ff);
    wr(`APP_ADDR_IFLAG, 32'h01, `APP_RESP_OKAY);
    settle(4);
    rc(`APP_ADDR_IFLAG, 32'h00, 32'h03);
    chk("irq", 1'b0, irq_out_ff);
    wr(`APP_ADDR_ALT, 32'h10, `APP_RESP_OKAY);
    settle(4);
    rc(`APP_ADDR_IFLAG, 32'h01, 32'h03);
    chk("irq", 1'b1, irq_out_ff);
    ext_en <= 8'h00;
    settle(4);
    wr(`APP_ADDR_IFLAG, 32'h03, `APP_RESP_OKAY);
    wr(`APP_ADDR_DRV, 32'h00, `APP_RESP_OKAY);
    wr(`APP_ADDR_DIR, 32'hbf, `APP_RESP_OKAY);
    settle(6);
    rc(`APP_ADDR_IFLAG, 32'h00, 32'h03);
    chk("irq", 1'b0, irq_out_ff);
    // pin 7 level trigger while its flag stays masked
    wr(`APP_ADDR_ALT, 32'h20, `APP_RESP_OKAY);
    ext_en <= 8'h80;
    settle(6);
    rc(`APP_ADDR_IFLAG, 32'h02, 32'h03);
    chk("irq", 1'b0, irq_out_ff);
    test_done;
  end
endmodule // tb_aux_pin_port
